// ---- src/pixel_serializer.sv ----
`timescale 1ns/1ns
`default_nettype none

// Link front end: the 21-bit pixel word is captured in the pixel clock
// domain and presented as three seven-slot lane words plus the clock lane
// slot pattern; the analog shifter sends the slots at seven times the
// pixel rate and forms each complementary pair from these levels.
module pixel_serializer #(
    parameter int unsigned LOCK_CYCLES_P = pixel_link_pkg::LOCK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Pins.
    input  wire logic        power_down_n,
    input  wire logic        strobe_edge_select,
    input  wire logic        pixel_clock_in,
    input  wire logic [5:0]  red,
    input  wire logic [5:0]  green,
    input  wire logic [5:0]  blue,
    input  wire logic        line_sync,
    input  wire logic        frame_sync,
    input  wire logic        pixel_valid,
    output logic [20:0]      serial_data_pairs,
    output logic             serial_data_oe,
    output logic [6:0]       forwarded_clock_pair,
    output logic             forwarded_clock_oe
);

    // Power-down pin synchroniser into the system domain.
    logic        pd_s1_r;
    logic        pd_s2_r;
    // Strobe pin synchroniser for the status view.
    logic        edge_c1_r;
    logic        edge_c2_r;
    // Software enable and relock state.
    logic        soft_en_r;
    logic        tx_enable_r;
    logic [17:0] lock_cnt_r;
    logic        run_req;
    // APB decode.
    logic        acc;
    logic        hit;

    // Both synchronisers: only the second stage is read by logic.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pd_s1_r   <= 1'b0;
            pd_s2_r   <= 1'b0;
            edge_c1_r <= 1'b0;
            edge_c2_r <= 1'b0;
        end else begin
            pd_s1_r   <= power_down_n;
            pd_s2_r   <= pd_s1_r;
            edge_c1_r <= strobe_edge_select;
            edge_c2_r <= edge_c1_r;
        end
    end

    // The link may run only while the pin and software both allow it.
    assign run_req = pd_s2_r && soft_en_r;

    // Relock sequencer: any drop of the request clears the count and the
    // enable at once, whatever the state, and a new request waits the
    // full lock time again.  This stands in for the PLL and its reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lock_cnt_r  <= 18'h0_0000;
            tx_enable_r <= 1'b0;
        // RULE6: drop from any state.
        end else if (!run_req) begin
            lock_cnt_r  <= 18'h0_0000;
            tx_enable_r <= 1'b0;
        end else if (!tx_enable_r) begin
            // RULE11: enable after lock time.
            if (lock_cnt_r == LOCK_CYCLES_P[17:0] - 18'h0_0001) begin
                tx_enable_r <= 1'b1;
            end else begin
                // RULE10: relock before output.
                lock_cnt_r <= lock_cnt_r + 18'h0_0001;
            end
        end
    end

    // Bus decode: a zero-wait slave, so pready is simply high.
    assign acc     = psel && penable;
    assign hit     = (paddr == pixel_link_pkg::CTRL_OFS) ||
                     (paddr == pixel_link_pkg::STATUS_OFS) ||
                     (paddr == pixel_link_pkg::LOCK_CNT_OFS);
    assign pready  = 1'b1;
    assign pslverr = acc && !hit;

    // Control register write, taken only in the access phase.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            soft_en_r <= pixel_link_pkg::CTRL_ENABLE_RST;
        end else if (acc && pwrite &&
                     paddr == pixel_link_pkg::CTRL_OFS) begin
            soft_en_r <= pwdata[pixel_link_pkg::CTRL_ENABLE_BIT];
        end
    end

    // Read data is latched in the setup phase so it is a flop output in
    // the access phase; unmapped addresses read as zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                pixel_link_pkg::CTRL_OFS: begin
                    prdata <= {31'h0000_0000, soft_en_r};
                end
                pixel_link_pkg::STATUS_OFS: begin
                    prdata <= {29'h0000_0000, edge_c2_r, pd_s2_r,
                               tx_enable_r};
                end
                pixel_link_pkg::LOCK_CNT_OFS: begin
                    prdata <= {14'h0000, lock_cnt_r};
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Link domain: enable and strobe select cross by two flops each.
    // The link domain has no reset of its own; the synchronised enable
    // serves as its synchronous reset, so it needs running pixel clock
    // edges to settle, which the host guarantees whenever enabled.
    logic        run_l1_r;
    logic        run_l2_r;
    logic        edge_l1_r;
    logic        edge_l2_r;
    logic [20:0] word_in;
    logic [20:0] cap_fall_r;

    always_ff @(posedge pixel_clock_in) begin
        run_l1_r  <= tx_enable_r;
        run_l2_r  <= run_l1_r;
        edge_l1_r <= strobe_edge_select;
        edge_l2_r <= edge_l1_r;
    end

    // RULE1: gather the 21 inputs.
    assign word_in = {pixel_valid, frame_sync, line_sync,
                      blue, green, red};

    // Falling-edge capture, used when the select is low or left open.
    always_ff @(negedge pixel_clock_in) begin
        cap_fall_r <= word_in;
    end

    // Lane output registers; data and clock lanes float together.
    always_ff @(posedge pixel_clock_in) begin
        // RULE5: float outputs in power-down.
        if (!run_l2_r) begin
            serial_data_pairs    <= 21'h00_0000;
            forwarded_clock_pair <= 7'h00;
            serial_data_oe       <= 1'b0;
            forwarded_clock_oe   <= 1'b0;
        end else begin
            // RULE3: rising edge sampling.
            if (edge_l2_r) begin
                // RULE17: lane slot order.
                serial_data_pairs <= word_in;
            end else begin
                // RULE4: falling edge default.
                serial_data_pairs <= cap_fall_r;
            end
            // RULE2: three lanes plus clock.
            forwarded_clock_pair <= pixel_link_pkg::CLK_PATTERN;
            serial_data_oe       <= 1'b1;
            forwarded_clock_oe   <= 1'b1;
        end
    end

    // Checks in the system domain.
    sequence s_release;
        $rose(run_req);
    endsequence

    sequence s_hold_off;
        !tx_enable_r [*8];
    endsequence

    property p_relock;
        @(posedge clk) disable iff (!rst_n)
        s_release |=> s_hold_off;
    endproperty
    a_relock: assert property (p_relock) // RULE10
        else $error("Enable rose without relock wait.");

    property p_lock_time;
        @(posedge clk) disable iff (!rst_n)
        $rose(tx_enable_r) |->
            $past(lock_cnt_r) == LOCK_CYCLES_P[17:0] - 18'h0_0001;
    endproperty
    a_lock_time: assert property (p_lock_time) // RULE11
        else $error("Enable rose before the lock time.");

    property p_pd_any;
        @(posedge clk) disable iff (!rst_n)
        !pd_s2_r |=> !tx_enable_r && lock_cnt_r == 18'h0_0000;
    endproperty
    a_pd_any: assert property (p_pd_any) // RULE6
        else $error("Power-down did not stop the link.");

    // Checks in the link domain; the enable level doubles as its reset.
    property p_float;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        !run_l2_r |=> !serial_data_oe && !forwarded_clock_oe;
    endproperty
    a_float: assert property (p_float) // RULE5
        else $error("Outputs driven during power-down.");

    property p_rise;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        run_l2_r && edge_l2_r |=> serial_data_pairs == $past(word_in);
    endproperty
    a_rise: assert property (p_rise) // RULE3
        else $error("Rising strobe word mismatch.");

    property p_fall;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        run_l2_r && !edge_l2_r |=> serial_data_pairs == $past(cap_fall_r);
    endproperty
    a_fall: assert property (p_fall) // RULE4
        else $error("Falling strobe word mismatch.");

    property p_lanes;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        run_l2_r && edge_l2_r |=>
            serial_data_pairs[20:14] == {$past(pixel_valid),
                $past(frame_sync), $past(line_sync), $past(blue[5:2])};
    endproperty
    a_lanes: assert property (p_lanes) // RULE17
        else $error("Top lane slot order wrong.");

    property p_clock_lane;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        serial_data_oe |-> forwarded_clock_oe &&
            forwarded_clock_pair == pixel_link_pkg::CLK_PATTERN;
    endproperty
    a_clock_lane: assert property (p_clock_lane) // RULE2
        else $error("Clock lane not with data lanes.");

    property p_inputs;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        run_l2_r && edge_l2_r |=>
            serial_data_pairs[5:0] == $past(red);
    endproperty
    a_inputs: assert property (p_inputs) // RULE1
        else $error("Red field not carried.");

    // Further system domain checks on the synchroniser, the sequencer and the control register write.
    // They watch the counter step by step, since a broken increment would
    // still let the enable rise eventually and slip past the timing check.
    sequence s_clean_sync;
        $past(rst_n) && $past(rst_n, 2);
    endsequence

    // The power-down pin reaches logic exactly two edges late.
    property p_pd_sync;
        @(posedge clk) disable iff (!rst_n)
        s_clean_sync |-> pd_s2_r == $past(power_down_n, 2);
    endproperty
    a_pd_sync: assert property (p_pd_sync) // RULE6
        else $error("Power-down synchroniser delay wrong.");

    // A falling request clears the lock enable at the very next edge.
    property p_drop;
        @(posedge clk) disable iff (!rst_n)
        $fell(run_req) |=> !tx_enable_r;
    endproperty
    a_drop: assert property (p_drop) // RULE6
        else $error("Enable survived a dropped request.");

    // While waiting for lock the counter advances by one each edge.
    property p_count_up;
        @(posedge clk) disable iff (!rst_n)
        run_req && !tx_enable_r &&
            lock_cnt_r != LOCK_CYCLES_P[17:0] - 18'h0_0001 |=>
            lock_cnt_r == $past(lock_cnt_r) + 18'h0_0001;
    endproperty
    a_count_up: assert property (p_count_up) // RULE10
        else $error("Relock counter did not advance.");

    // Once locked, the enable stays up while the request stands.
    property p_enable_hold;
        @(posedge clk) disable iff (!rst_n)
        tx_enable_r && run_req |=> tx_enable_r;
    endproperty
    a_enable_hold: assert property (p_enable_hold) // RULE11
        else $error("Enable dropped with request standing.");

    // A write to the control word loads the software enable at the next edge.
    property p_ctrl_write;
        @(posedge clk) disable iff (!rst_n)
        acc && pwrite && paddr == pixel_link_pkg::CTRL_OFS |=>
            soft_en_r == $past(pwdata[pixel_link_pkg::CTRL_ENABLE_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) // RULE6
        else $error("Control enable not written.");

    // Link domain: the two output enables always move together.
    property p_oe_pair;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        serial_data_oe == forwarded_clock_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) // RULE2
        else $error("Clock and data enables differ.");

    // Floated lanes carry zero, so no stale word leaks on release.
    property p_float_zero;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        !serial_data_oe |-> serial_data_pairs == 21'h00_0000 &&
            forwarded_clock_pair == 7'h00;
    endproperty
    a_float_zero: assert property (p_float_zero) // RULE5
        else $error("Floated lanes not cleared.");

    // Lanes may only come up after the synchronised lock enable.
    property p_drive_gate;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        $rose(serial_data_oe) |-> $past(run_l2_r);
    endproperty
    a_drive_gate: assert property (p_drive_gate) // RULE10
        else $error("Lanes driven before lock enable.");

    // Strobe select reaches the link domain through two flops.
    property p_edge_sync;
        @(posedge pixel_clock_in) disable iff (!rst_n)
        edge_l2_r == $past(edge_l1_r);
    endproperty
    a_edge_sync: assert property (p_edge_sync) // RULE3
        else $error("Strobe select synchroniser broken.");

endmodule

`default_nettype wire

// ---- inc/pixel_link_pkg.sv ----
// Functional notes
// RULE1: Accept 21 inputs: 18 colour, three timing.
// RULE2: Three data lanes plus forwarded clock lane.
// RULE3: Strobe select high samples on rising edge.
// RULE4: Strobe select low or open samples falling.
// RULE5: Power-down low floats outputs, draws little.
// RULE6: Power-down low acts from any state.
// RULE7: Host keeps pixel clock while enabled.
// RULE8: Host asserts power-down when clock stops.
// RULE9: Host releases power-down only after clock returns.
// RULE10: On release, reset and relock before output.
// RULE11: Outputs start toggling 10 ms after release.
// RULE12: Late clock needs power-down held meanwhile.
// RULE13: Receiver holds data when link clock stops.
// RULE14: Receiver drives open lanes' outputs high.
// RULE15: Receiver keeps last data with clock open.
// RULE16: Receiver holds clock output low when open.
// RULE17: Seven bits per lane, fixed order.
package pixel_link_pkg;

    // System clock rate and the relock wait before the lanes toggle.
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned LOCK_TIME_MS = 10;
    localparam int unsigned LOCK_CYCLES  = LOCK_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned LOCK_CNT_W   = 18;

    // Word geometry: three lanes of seven bit slots.
    localparam int unsigned COLOR_W     = 6;
    localparam int unsigned LANES       = 3;
    localparam int unsigned SLOTS       = 7;
    localparam int unsigned WORD_W      = LANES * SLOTS;

    // Clock lane slot pattern, first slot in the top bit.
    localparam logic [6:0] CLK_PATTERN = 7'h63;

    // Register byte offsets.
    localparam logic [11:0] CTRL_OFS      = 12'h000;
    localparam logic [11:0] STATUS_OFS    = 12'h004;
    localparam logic [11:0] LOCK_CNT_OFS  = 12'h008;

    // Control fields and reset value.
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam logic        CTRL_ENABLE_RST = 1'b1;

    // Status fields.
    localparam int unsigned STAT_LOCKED_BIT = 0;
    localparam int unsigned STAT_PWR_BIT    = 1;
    localparam int unsigned STAT_EDGE_BIT   = 2;

endpackage

// ---- sim/pixel_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Host model: makes the pixel clock and words, and owns the power-down pin.
module pixel_host_model (
    input  wire logic        clk_on,
    input  wire logic        want_up,
    output logic             pixel_clock_in,
    output logic             power_down_n,
    output logic [5:0]       red,
    output logic [5:0]       green,
    output logic [5:0]       blue,
    output logic             line_sync,
    output logic             frame_sync,
    output logic             pixel_valid,
    output logic [20:0]      word,
    output logic [20:0]      prev_word
);
    logic run;   // Gate of the pixel clock.
    logic seen;  // A clock edge came since the clock returned.
    // clock while enabled. It parks low so no half pulse is left.
    initial begin
        pixel_clock_in = 1'b0;
        forever begin
            #24;
            if (run || pixel_clock_in) pixel_clock_in = ~pixel_clock_in;
        end
    end
    // The pin drops at once and the clock stops eight edges later.
    initial begin
        run = 1'b0;
        forever begin
            if (clk_on === 1'b1) begin
                run = 1'b1;
                @(clk_on);
            end else if (run) begin
                repeat (8) @(posedge pixel_clock_in);
                run = 1'b0;
            end else @(clk_on);
        end
    end
    // pin held low until clock returns.
    initial seen = 1'b0;
    always @(posedge pixel_clock_in or negedge clk_on) begin
        if (!clk_on) seen <= 1'b0;
        else seen <= 1'b1;
    end
    assign power_down_n = want_up & clk_on & seen;
    // Words move on the falling edge; prev_word keeps the one before.
    initial word = 21'h1_5A3C;
    always @(negedge pixel_clock_in) begin
        prev_word <= word;
        word      <= word + 21'h0_9A53;
    end
    assign {pixel_valid, frame_sync, line_sync, blue, green, red} = word;
endmodule

// Receiver model: rebuilds the word from the lanes at each rising link clock edge while the clock lane is driven.
module pixel_link_receiver_model (
    input  wire logic        link_clk,
    input  wire logic [20:0] lanes,
    input  wire logic        lanes_oe,
    input  wire logic        clk_lane_oe,
    output logic [20:0]      receiver_parallel_outputs,
    output logic             rx_clock
);
    // clock output low while the clock lane is open.
    assign rx_clock = clk_lane_oe & link_clk;
    // no clock edge, so the outputs hold their last word.
    // open data lanes with a live clock read as all ones.
    always @(posedge link_clk) begin
        if (clk_lane_oe) receiver_parallel_outputs <= lanes_oe ? lanes : '1;
    end
endmodule
`default_nettype wire

// ---- sim/lvds_pixel_serializer_21bit_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module lvds_pixel_serializer_21bit_bench;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pd_n, sel, pclk, sync_l, sync_f, pv, d_oe, c_oe, clk_on, up, e;
    logic [5:0] r, g, b;
    logic [20:0] sd, w, pw, rxo, last_sd;
    logic rxc;
    logic [6:0] fc;
    int bad_count, checks_done, n;
    pixel_serializer #(.LOCK_CYCLES_P(40)) DUT (.clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .power_down_n(pd_n), .strobe_edge_select(sel),
        .pixel_clock_in(pclk), .red(r), .green(g), .blue(b),
        .line_sync(sync_l), .frame_sync(sync_f), .pixel_valid(pv),
        .serial_data_pairs(sd), .serial_data_oe(d_oe),
        .forwarded_clock_pair(fc), .forwarded_clock_oe(c_oe));
    pixel_host_model host (.clk_on(clk_on), .want_up(up),
        .pixel_clock_in(pclk), .power_down_n(pd_n), .red(r), .green(g),
        .blue(b), .line_sync(sync_l), .frame_sync(sync_f),
        .pixel_valid(pv), .word(w), .prev_word(pw));
    pixel_link_receiver_model rx (.link_clk(pclk), .lanes(sd),
        .lanes_oe(d_oe), .clk_lane_oe(c_oe),
        .receiver_parallel_outputs(rxo), .rx_clock(rxc));
    // Last word put on the lanes while the clock lane was driven.
    always @(posedge pclk) begin
        if (c_oe) last_sd <= sd;
    end
    // System clock, 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Reports and counts one compare.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, which this slave gives at once.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) bad_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits until the data lane enable reaches v, counting clk cycles.
    task automatic wait_oe(input logic v);
        n = 0;
        while (d_oe !== v && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask
    // Compares four link words; the strobe edge picks which word is due.
    task automatic lanes(input logic rise);
        repeat (4) begin
            @(posedge pclk);
            #1;
            check(sd, rise ? w : pw);
            check({c_oe, fc}, {1'b1, 7'h63});
        end
    endtask
    // Register reset values and an unmapped address.
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        check(q, 32'h0000_0001);
        apb(1'b0, 12'h004, 32'h0);
        check(q[0], 1'b0);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        apb(1'b0, 12'h00C, 32'h0);
        check(e, 1'b1);
        check(q, 32'h0);
        $display("test regs done");
    endtask
    // Release power-down; lanes wait out the lock count, then carry words.
    task automatic t_lock(input logic rise);
        @(posedge clk);
        {sel, clk_on, up} <= {rise, 2'b11};
        wait_oe(1'b1);
        check(n >= 42 && n <= 56, 1'b1);
        lanes(rise);
        apb(1'b0, 12'h004, 32'h0);
        check(q[2:0], {rise, 2'b11});
        $display("test lock done");
    endtask
    // Disable and enable again through the control register.
    task automatic t_ctrl;
        apb(1'b1, 12'h000, 32'h0);
        wait_oe(1'b0);
        check({c_oe, fc, sd}, 29'h0);
        apb(1'b1, 12'h000, 32'h1);
        wait_oe(1'b1);
        check(n >= 40 && n <= 56, 1'b1);
        lanes(1'b1);
        $display("test ctrl done");
    endtask
    // Clock stop: host drops the pin, outputs float from a running link.
    task automatic t_down;
        @(posedge clk);
        clk_on <= 1'b0;
        wait_oe(1'b0);
        check(n < 20, 1'b1);
        check({c_oe, fc, sd}, 29'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(q[1:0], 2'b00);
        apb(1'b0, 12'h008, 32'h0);
        check(q, 32'h0);
        check(rxo, last_sd);
        check(rxc, 1'b0);
        $display("test down done");
    endtask
    // Verdict, printed once.
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // A hang well past the expected run counts as a mismatch.
    initial begin
        #2_000_000;
        bad_count++;
        final_report;
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {sel, up, clk_on} = 3'b001;
        bad_count = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_lock(1'b1);
        t_ctrl;
        t_down;
        t_lock(1'b0);
        final_report;
    end
endmodule
`default_nettype wire
